// [verilog/fpq_scheduler.sv]
// egress priority classifier, four-queue scheduler and tag rewriter for one port
//
// Functional notes
// - four outbound queues per port; each frame sits in exactly one
// - one strict/fair selection governs all four queues of the port
// - strict: serve highest non-empty queue first, lower only when higher empty
// - fair: round sends up to 8 urgent, 4 expedited, 2 normal, 1 background
// - tag honour enable: tagged frames use tag map; cleared ignores tags
// - IP honour, no tag override: queue is IP priority divided by 64
// - precedence picks tag or IP when both present and enabled
// - frames without usable priority go to the default queue
// - IP priority field is eight bits, 0 to 255, zero the default
// - tag priority is three bits, 0 to 7, each mapped to a queue
// - transparent port keeps the tag state the frame arrived with
// - edge port strips tags from every outgoing frame
// - network port tags untagged frames with priority queue times two
// - core port adds an outer tag to every frame
// - queues ordered background, normal, expedited, urgent; map fully configurable
// - reset map: 1,2 bg; 0,3 normal; 4,5 expedited; 6,7 urgent
`timescale 1ns/1ps
module fpq_scheduler (
  input  wire logic        clk,
  input  wire logic        rstN,
  // register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdata,
  // ingress frame descriptors from the switch fabric
  input  wire logic        inValid,
  output logic             inReady,
  input  wire logic [7:0]  inId,
  input  wire logic        inTagged,
  input  wire logic [2:0]  inTagPri,
  input  wire logic        inHasIp,
  input  wire logic [7:0]  inIpPri,
  // egress frame descriptors toward the link
  output logic             outValid,
  input  wire logic        outReady,
  output logic      [7:0]  outId,
  output logic      [1:0]  outQueue,
  output logic      [1:0]  outTagCount,
  output logic      [2:0]  outOuterPri,
  output logic      [2:0]  outInnerPri
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [fpq_pkg::CTRL_WIDTH-1:0] ctrl_r;
  logic [15:0]                    map_r;
  logic [31:0]                    rdata_r;

  wire        fairMode  = ctrl_r[fpq_pkg::CTRL_FAIR_BIT];
  wire        honor_tag_priority_enable = ctrl_r[fpq_pkg::CTRL_TAG_BIT];
  wire        honor_ip_priority_enable  = ctrl_r[fpq_pkg::CTRL_IP_BIT];
  wire        ipWins    = ctrl_r[fpq_pkg::CTRL_IPWIN_BIT];
  wire [1:0]  defQueue  = ctrl_r[fpq_pkg::CTRL_DEFQ_LSB +: 2];
  wire [1:0]  portType  = ctrl_r[fpq_pkg::CTRL_TYPE_LSB +: 2];

  // address decode
  wire selCtrl = (regAddr == fpq_pkg::CTRL_OFS);
  wire selMap  = (regAddr == fpq_pkg::MAP_OFS);
  wire selStat = (regAddr == fpq_pkg::STAT_OFS);

  logic [fpq_pkg::LVL_W-1:0] lvl [fpq_pkg::NUM_Q];
  logic [1:0]                curQ_r;
  wire  [31:0] statWord = {18'h0_0000, curQ_r, lvl[3], lvl[2], lvl[1], lvl[0]};

  // read mux; unmapped offsets read as zero
  wire [31:0] rdMux = selCtrl ? {24'h00_0000, ctrl_r} :
                      selMap  ? {16'h0000, map_r} :
                      selStat ? statWord : 32'h0000_0000;

  // one control word serves this port's four queues, so the policy is per port
  // per-port mode register
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      ctrl_r <= fpq_pkg::CTRL_RST;
      map_r  <= fpq_pkg::MAP_RST;
    end else if (regWr && selCtrl) begin
      ctrl_r <= regWdata[fpq_pkg::CTRL_WIDTH-1:0];
    end else if (regWr && selMap) begin
      map_r  <= regWdata[15:0];
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= regRd ? rdMux : 32'h0000_0000;
    end
  end
  assign regRdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // classification
  // tags only count when honoured
  wire tagUse = honor_tag_priority_enable && inTagged;
  wire ipUse  = honor_ip_priority_enable && inHasIp;
  // each priority has its own map field
  wire [1:0] mapQ = map_r[{inTagPri, 1'b0} +: 2];
  // divide by 64 keeps the top two bits
  // full eight-bit field, zero lands in background
  wire [1:0] ipQ  = inIpPri[7:6];
  wire [1:0] classQ = (tagUse && ipUse) ? (ipWins ? ipQ : mapQ) :
                      tagUse ? mapQ :
                      ipUse  ? ipQ  : defQueue;

  logic inReady_r;
  wire  accept = inValid && inReady_r;
  wire [fpq_pkg::DESC_W-1:0] inDesc = {inTagged, inTagPri, inId};

  // ready is registered, so it looks one frame ahead: a queue at depth-1
  // can still take the one frame that may arrive before ready drops
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      inReady_r <= 1'b0;
    end else begin
      inReady_r <= (lvl[0] < 3'd3) && (lvl[1] < 3'd3) && (lvl[2] < 3'd3) && (lvl[3] < 3'd3);
    end
  end
  assign inReady = inReady_r;

  ////////////////////////////////////////////////////////////////////////////
  // queues
  logic [fpq_pkg::NUM_Q-1:0]  qEmpty;
  logic [fpq_pkg::NUM_Q-1:0]  qPush;
  logic [fpq_pkg::NUM_Q-1:0]  qPop;
  logic [fpq_pkg::DESC_W-1:0] qHead [fpq_pkg::NUM_Q];

  // four queues, one push target each
  genvar gq;
  generate
    for (gq = 0; gq < fpq_pkg::NUM_Q; gq++) begin : gQueue
      assign qPush[gq] = accept && (classQ == 2'(gq));
      fpq_queue #(
        .W     (fpq_pkg::DESC_W),
        .DEPTH (fpq_pkg::Q_DEPTH),
        .LW    (fpq_pkg::LVL_W)
      ) uQueue (
        .clk      (clk),
        .rstN     (rstN),
        .push     (qPush[gq]),
        .pushData (inDesc),
        .pop      (qPop[gq]),
        .popData  (qHead[gq]),
        .empty    (qEmpty[gq]),
        .level    (lvl[gq])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // scheduler
  logic [3:0] sent_r;
  logic [1:0] sel;
  logic       selValid;
  logic       selNewRun;
  logic [3:0] curWeight;

  always_comb begin
    case (curQ_r)
      fpq_pkg::Q_URGENT:    curWeight = fpq_pkg::W_URGENT;
      fpq_pkg::Q_EXPEDITED: curWeight = fpq_pkg::W_EXPEDITED;
      fpq_pkg::Q_NORMAL:    curWeight = fpq_pkg::W_NORMAL;
      default:              curWeight = fpq_pkg::W_BACKGROUND;
    endcase
  end

  // fair search walks downward from the current queue and wraps to urgent,
  // which opens a new round; step four revisits the current queue afresh so
  // a lone busy queue never stalls the link
  // strict picks highest non-empty
  // skip empty or spent queues combinationally
  always_comb begin
    logic [1:0] q;
    logic       hit;
    q         = 2'd0;
    hit       = 1'b0;
    sel       = fpq_pkg::Q_BACKGROUND;
    selValid  = 1'b0;
    selNewRun = 1'b0;
    if (!fairMode) begin
      for (int k = 3; k >= 0; k--) begin
        if (!selValid && !qEmpty[k]) begin
          sel      = 2'(k);
          selValid = 1'b1;
        end
      end
    end else begin
      for (int k = 0; k <= 4; k++) begin
        q   = curQ_r - 2'(k);
        hit = !qEmpty[q] && ((k != 0) || (sent_r < curWeight));
        if (!selValid && hit) begin
          sel       = q;
          selValid  = 1'b1;
          selNewRun = (k != 0);
        end
      end
    end
  end

  logic outValid_r;
  wire  slotFree = !outValid_r || outReady;
  wire  doPop    = slotFree && selValid;

  generate
    for (gq = 0; gq < fpq_pkg::NUM_Q; gq++) begin : gPop
      assign qPop[gq] = doPop && (sel == 2'(gq));
    end
  endgenerate

  // round bookkeeping: frames sent from the queue now being served
  // count frames against the weight
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      curQ_r <= fpq_pkg::Q_URGENT;
      sent_r <= 4'h0;
    end else if (doPop) begin
      curQ_r <= sel;
      sent_r <= selNewRun ? 4'h1 : sent_r + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // egress tag rewrite
  wire [fpq_pkg::DESC_W-1:0] head = qHead[sel];
  wire       hTagged = head[fpq_pkg::D_TAG_BIT];
  wire [2:0] hPri    = head[fpq_pkg::D_PRI_LSB +: 3];
  wire [2:0] qPri    = {sel, 1'b0};
  logic [1:0] tagCnt;
  logic [2:0] outerPri;
  logic [2:0] innerPri;

  // network tags untagged with queue times two
  // core always adds an outer tag
  always_comb begin
    tagCnt   = {1'b0, hTagged};
    outerPri = hTagged ? hPri : 3'd0;
    innerPri = 3'd0;
    case (portType)
      fpq_pkg::PT_EDGE: begin
        tagCnt   = 2'd0;
        outerPri = 3'd0;
      end
      fpq_pkg::PT_NETWORK: begin
        if (!hTagged) begin
          tagCnt   = 2'd1;
          outerPri = qPri;
        end
      end
      fpq_pkg::PT_CORE: begin
        tagCnt   = hTagged ? 2'd2 : 2'd1;
        outerPri = qPri;
        innerPri = hTagged ? hPri : 3'd0;
      end
      default: begin
      end
    endcase
  end

  logic [7:0] outId_r;
  logic [1:0] outQueue_r;
  logic [1:0] outTagCount_r;
  logic [2:0] outOuterPri_r;
  logic [2:0] outInnerPri_r;

  // output slot: loads on pop, clears when taken with nothing behind it
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      outValid_r    <= 1'b0;
      outId_r       <= 8'h00;
      outQueue_r    <= 2'd0;
      outTagCount_r <= 2'd0;
      outOuterPri_r <= 3'd0;
      outInnerPri_r <= 3'd0;
    end else if (doPop) begin
      outValid_r    <= 1'b1;
      outId_r       <= head[fpq_pkg::ID_W-1:0];
      outQueue_r    <= sel;
      outTagCount_r <= tagCnt;
      outOuterPri_r <= outerPri;
      outInnerPri_r <= innerPri;
    end else if (outReady) begin
      outValid_r    <= 1'b0;
    end
  end

  assign outValid    = outValid_r;
  assign outId       = outId_r;
  assign outQueue    = outQueue_r;
  assign outTagCount = outTagCount_r;
  assign outOuterPri = outOuterPri_r;
  assign outInnerPri = outInnerPri_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_ONE_QUEUE: assert property (@(posedge clk) disable iff (!rstN)
    accept |-> $onehot(qPush)) else $error("frame not in exactly one queue");

  AST_STRICT_ORDER: assert property (@(posedge clk) disable iff (!rstN)
    (doPop && !fairMode) |-> (((~qEmpty) >> (sel + 3'd1)) == 4'h0))
    else $error("strict pop while a higher queue holds frames");

  AST_FAIR_WEIGHT: assert property (@(posedge clk) disable iff (!rstN)
    (doPop && fairMode && !selNewRun) |-> (sel == curQ_r) && (sent_r < curWeight))
    else $error("fair queue exceeded its round allowance");

  AST_IP_CLASS: assert property (@(posedge clk) disable iff (!rstN)
    (accept && ipUse && !tagUse) |-> qPush[inIpPri[7:6]])
    else $error("ip frame not queued by priority over 64");

  AST_DEFAULT_Q: assert property (@(posedge clk) disable iff (!rstN)
    (accept && !ipUse && !tagUse) |-> qPush[defQueue])
    else $error("frame without usable priority missed default queue");

  AST_EDGE_STRIP: assert property (@(posedge clk) disable iff (!rstN)
    (doPop && portType == fpq_pkg::PT_EDGE) |=> outValid && outTagCount == 2'd0)
    else $error("edge port sent a tagged frame");

  AST_NET_ADD: assert property (@(posedge clk) disable iff (!rstN)
    (doPop && portType == fpq_pkg::PT_NETWORK && !hTagged)
    |=> outTagCount == 2'd1 && outOuterPri == {$past(sel), 1'b0})
    else $error("network port tag priority not queue times two");

  AST_CORE_DOUBLE: assert property (@(posedge clk) disable iff (!rstN)
    (doPop && portType == fpq_pkg::PT_CORE && hTagged) |=> outTagCount == 2'd2)
    else $error("core port did not double tag");

  AST_FAIR_NO_IDLE: assert property (@(posedge clk) disable iff (!rstN)
    (fairMode && slotFree && qEmpty != 4'hF) |-> doPop)
    else $error("fair scheduler idled with frames waiting");
endmodule

// [shared/fpq_pkg.sv]
// constants shared by the egress priority queue scheduler
package fpq_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] MAP_OFS  = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  // control register field positions
  localparam int CTRL_FAIR_BIT  = 0;
  localparam int CTRL_TAG_BIT   = 1;
  localparam int CTRL_IP_BIT    = 2;
  localparam int CTRL_IPWIN_BIT = 3;
  localparam int CTRL_DEFQ_LSB  = 4;
  localparam int CTRL_TYPE_LSB  = 6;
  localparam int CTRL_WIDTH     = 8;
  // status register field positions
  localparam int STAT_LVL_LSB = 0;
  localparam int STAT_CUR_LSB = 12;
  // reset values: strict, both honours off, tag wins, default normal, transparent
  localparam logic [7:0]  CTRL_RST = 8'h10;
  // tag priority map, two bits per priority: 1,2->bg 0,3->nrm 4,5->exp 6,7->urg
  localparam logic [15:0] MAP_RST  = 16'hFA41;
  // queue codes
  localparam logic [1:0] Q_BACKGROUND = 2'd0;
  localparam logic [1:0] Q_NORMAL     = 2'd1;
  localparam logic [1:0] Q_EXPEDITED  = 2'd2;
  localparam logic [1:0] Q_URGENT     = 2'd3;
  // port types
  localparam logic [1:0] PT_TRANSPARENT = 2'd0;
  localparam logic [1:0] PT_EDGE        = 2'd1;
  localparam logic [1:0] PT_NETWORK     = 2'd2;
  localparam logic [1:0] PT_CORE        = 2'd3;
  // fair round weights per queue
  localparam logic [3:0] W_URGENT     = 4'd8;
  localparam logic [3:0] W_EXPEDITED  = 4'd4;
  localparam logic [3:0] W_NORMAL     = 4'd2;
  localparam logic [3:0] W_BACKGROUND = 4'd1;
  // queue geometry and descriptor layout
  localparam int NUM_Q    = 4;
  localparam int Q_DEPTH  = 4;
  localparam int LVL_W    = 3;
  localparam int ID_W     = 8;
  localparam int DESC_W   = 12;
  localparam int D_TAG_BIT = 11;
  localparam int D_PRI_LSB = 8;
endpackage

// [verilog/fpq_queue.sv]
// one outbound frame descriptor queue
`timescale 1ns/1ps
module fpq_queue #(
  parameter int W     = 12,
  parameter int DEPTH = 4,
  parameter int LW    = 3
) (
  input  wire logic          clk,
  input  wire logic          rstN,
  input  wire logic          push,
  input  wire logic [W-1:0]  pushData,
  input  wire logic          pop,
  output logic      [W-1:0]  popData,
  output logic               empty,
  output logic      [LW-1:0] level
);
  logic [W-1:0]    mem [DEPTH];
  logic [LW-2:0]   wrPtr_r;
  logic [LW-2:0]   rdPtr_r;
  logic [LW-1:0]   level_r;

  assign popData = mem[rdPtr_r];
  assign empty   = (level_r == '0);
  assign level   = level_r;

  // storage has no reset; only valid slots are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_r] <= pushData;
    end
  end

  // pointers and fill level; caller never pushes when full nor pops when empty
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      level_r <= '0;
    end else begin
      wrPtr_r <= wrPtr_r + (LW-1)'(push);
      rdPtr_r <= rdPtr_r + (LW-1)'(pop);
      level_r <= level_r + LW'(push) - LW'(pop);
    end
  end
endmodule

// [testbench/fpq_link_sink.sv]
// link partner model that takes egress descriptors and logs them
`timescale 1ns/1ps
module fpq_link_sink (
  input  wire logic       clk,
  input  wire logic       rstN,
  input  wire logic       stall,
  input  wire logic       slow,
  input  wire logic       outValid,
  output logic            outReady,
  input  wire logic [7:0] outId,
  input  wire logic [1:0] outQueue,
  input  wire logic [1:0] outTagCount,
  input  wire logic [2:0] outOuterPri,
  input  wire logic [2:0] outInnerPri
);
  logic [17:0] rxLog [0:1023];
  int          rxCount;
  logic        phase_r;
  ////////////////////////////////////////////////////////////////////////////
  // ready moves only after an edge; slow mode accepts every other cycle
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      outReady <= 1'b0;
      phase_r  <= 1'b0;
    end else begin
      phase_r  <= ~phase_r;
      outReady <= !stall && (!slow || phase_r);
    end
  end
  // log each accepted descriptor in the order it left
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      rxCount <= 0;
    end else if (outValid && outReady) begin
      rxLog[rxCount[9:0]] <= {outId, outQueue, outTagCount, outOuterPri, outInnerPri};
      rxCount             <= rxCount + 1;
    end
  end
endmodule

// [testbench/fpq_scheduler_tb.sv]
// self-checking testbench for the egress priority scheduler
`timescale 1ns/1ps
module fpq_scheduler_tb;
  logic        clk, rstN, regWr, regRd, inValid, inTagged, inHasIp, stall, slow;
  logic        inReady, outValid, outReady;
  logic [7:0]  regAddr, inId, inIpPri, outId;
  logic [31:0] regWdata, regRdata;
  logic [2:0]  inTagPri, outOuterPri, outInnerPri;
  logic [1:0]  outQueue, outTagCount;
  int          bad_count, total_checks, rxSeen;

  fpq_scheduler dut (.clk(clk), .rstN(rstN), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .inValid(inValid),
    .inReady(inReady), .inId(inId), .inTagged(inTagged), .inTagPri(inTagPri),
    .inHasIp(inHasIp), .inIpPri(inIpPri), .outValid(outValid), .outReady(outReady),
    .outId(outId), .outQueue(outQueue), .outTagCount(outTagCount),
    .outOuterPri(outOuterPri), .outInnerPri(outInnerPri));
  fpq_link_sink link (.clk(clk), .rstN(rstN), .stall(stall), .slow(slow),
    .outValid(outValid), .outReady(outReady), .outId(outId), .outQueue(outQueue),
    .outTagCount(outTagCount), .outOuterPri(outOuterPri), .outInnerPri(outInnerPri));
  ////////////////////////////////////////////////////////////////////////////
  // clock at 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] expv, input logic [31:0] got);
    total_checks++;
    if (got !== expv) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, expv, got);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  // read data is looked at in the one cycle it stands
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] expv);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    chk("register read", expv, regRdata);
    // read data must fall back to zero once its cycle is over
    @(negedge clk);
    chk("read data after its cycle", 32'h0000_0000, regRdata);
  endtask
  // hold the descriptor until an edge sees ready high
  task automatic send(input logic [7:0] id, input logic tg, input logic [2:0] tp,
                      input logic hi, input logic [7:0] ip);
    @(posedge clk);
    inValid  <= 1'b1;
    inId     <= id;
    inTagged <= tg;
    inTagPri <= tp;
    inHasIp  <= hi;
    inIpPri  <= ip;
    do @(negedge clk); while (inReady !== 1'b1);
    @(posedge clk);
    inValid <= 1'b0;
  endtask
  task automatic expect_rx(input logic [17:0] rec);
    for (int i = 0; i < 100 && link.rxCount <= rxSeen; i++) @(negedge clk);
    chk("egress record", {14'h0, rec}, {14'h0, link.rxLog[rxSeen]});
    rxSeen++;
  endtask
  // expected queue and tag result of one frame
  function automatic logic [17:0] model(input logic [7:0] c, input logic [15:0] map,
      input logic [7:0] id, input logic tg, input logic [2:0] tp, input logic hi,
      input logic [7:0] ip);
    logic [1:0] q;
    logic [1:0] n;
    logic [2:0] o;
    logic [2:0] inner;
    if (c[1] && tg && !(c[2] && hi && c[3])) q = 2'(map >> {tp, 1'b0});
    else if (c[2] && hi) q = 2'(ip / 8'd64);
    else q = c[5:4];
    n = {1'b0, tg};
    o = tg ? tp : 3'd0;
    inner = 3'd0;
    case (c[7:6])
      fpq_pkg::PT_EDGE: begin
        n = 2'd0;
        o = 3'd0;
      end
      fpq_pkg::PT_NETWORK: if (!tg) begin
        n = 2'd1;
        o = {q, 1'b0};
      end
      fpq_pkg::PT_CORE: begin
        n = tg ? 2'd2 : 2'd1;
        inner = tg ? tp : 3'd0;
        o = {q, 1'b0};
      end
      default: ;
    endcase
    return {id, q, n, o, inner};
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_reset_regs;
    reg_rd(fpq_pkg::CTRL_OFS, 32'h0000_0010);
    reg_rd(fpq_pkg::MAP_OFS, 32'h0000_FA41);
    reg_rd(fpq_pkg::STAT_OFS, 32'h0000_3000);
    reg_wr(fpq_pkg::STAT_OFS, 32'h0000_0FFF);
    reg_wr(8'h0C, 32'h0000_00FF);
    reg_rd(fpq_pkg::STAT_OFS, 32'h0000_3000);
    reg_rd(8'h0C, 32'h0000_0000);
  endtask
  // every mix of enables, precedence, default queue and port type
  task automatic test_classify;
    logic [7:0] c;
    for (int k = 0; k < 128; k++) begin
      c = {k[6:5], k[1:0], k[4:2], 1'b0};
      reg_wr(fpq_pkg::CTRL_OFS, {24'h0, c});
      for (int f = 0; f < 4; f++) begin
        send(8'(k * 4 + f), f[0], 3'(k + f), f[1], 8'(k * 37 + f * 91));
        expect_rx(model(c, fpq_pkg::MAP_RST, 8'(k * 4 + f), f[0], 3'(k + f), f[1],
                        8'(k * 37 + f * 91)));
      end
    end
  endtask
  // several priorities may share a queue under a rewritten map
  task automatic test_custom_map;
    reg_wr(fpq_pkg::MAP_OFS, 32'h0000_1BE4);
    reg_rd(fpq_pkg::MAP_OFS, 32'h0000_1BE4);
    reg_wr(fpq_pkg::CTRL_OFS, 32'h0000_0002);
    for (int p = 0; p < 8; p++) begin
      send(8'(8'h30 + p), 1'b1, 3'(p), 1'b0, 8'h00);
      expect_rx(model(8'h02, 16'h1BE4, 8'(8'h30 + p), 1'b1, 3'(p), 1'b0, 8'h00));
    end
    reg_wr(fpq_pkg::MAP_OFS, {16'h0, fpq_pkg::MAP_RST});
  endtask
  // queue the frames with the link stalled, then let it drain
  task automatic fill_and_drain(input logic [7:0] c, input logic [2:0] pri [5],
                                input int order [5], input int cnt);
    reg_wr(fpq_pkg::CTRL_OFS, {24'h0, c});
    @(posedge clk);
    stall <= 1'b1;
    for (int i = 0; i < cnt; i++) send(8'(8'h40 + i), 1'b1, pri[i], 1'b0, 8'h00);
    repeat (3) @(posedge clk);
    stall <= 1'b0;
    for (int i = 0; i < cnt; i++)
      expect_rx(model(c, fpq_pkg::MAP_RST, 8'(8'h40 + order[i]), 1'b1, pri[order[i]],
                      1'b0, 8'h00));
  endtask
  task automatic test_strict;
    // background goes out first only because it was already offered
    fill_and_drain(8'h02, '{3'd1, 3'd0, 3'd4, 3'd6, 3'd0}, '{0, 3, 2, 1, 0}, 4);
  endtask
  task automatic test_fair;
    @(posedge clk);
    slow <= 1'b1;
    // normal spends its two, background gets its one, then normal again
    fill_and_drain(8'h03, '{3'd4, 3'd0, 3'd0, 3'd1, 3'd0}, '{0, 1, 2, 3, 4}, 5);
    slow <= 1'b0;
  endtask
  // a queue holding three frames must hold the fabric off until the link takes a frame from it
  task automatic test_backpressure;
    reg_wr(fpq_pkg::CTRL_OFS, 32'h0000_0002);
    @(posedge clk);
    stall <= 1'b1;
    // first frame waits in the output slot, the other three fill the urgent queue
    for (int i = 0; i < 4; i++) send(8'(8'h50 + i), 1'b1, 3'd6, 1'b0, 8'h00);
    reg_rd(fpq_pkg::STAT_OFS, 32'h0000_3600);
    @(negedge clk);
    chk("ingress ready with three queued", 32'h0000_0000, {31'h0, inReady});
    @(posedge clk);
    stall <= 1'b0;
    for (int i = 0; i < 4; i++)
      expect_rx(model(8'h02, fpq_pkg::MAP_RST, 8'(8'h50 + i), 1'b1, 3'd6,
                      1'b0, 8'h00));
    @(negedge clk);
    chk("ingress ready after drain", 32'h0000_0001, {31'h0, inReady});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    if (bad_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // cut a hang short well past the expected run length
  initial begin
    #800000;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    {rstN, regWr, regRd, inValid, inTagged, inHasIp, stall, slow} = 8'h00;
    {regAddr, inId, inIpPri, inTagPri} = 27'h0;
    regWdata = 32'h0000_0000;
    repeat (20) @(posedge clk);
    rstN <= 1'b1;
    repeat (2) @(posedge clk);
    test_reset_regs();
    test_classify();
    test_custom_map();
    test_strict();
    test_fair();
    test_backpressure();
    tally_and_finish();
  end
endmodule
